// File: design/rdsr_cfg.svh
`ifndef RDSR_CFG_SVH
`define RDSR_CFG_SVH
// register lengths in bits
`define RDSR_HALF_LEN 1024
`define RDSR_FULL_LEN 2048
// phase timing in ns and derived clk_sys cycles at 50 MHz
`define RDSR_CLK_MHZ 50
`define RDSR_PHASE_LOW_NS 120
`define RDSR_PHASE_LOW_CYC ((`RDSR_PHASE_LOW_NS * `RDSR_CLK_MHZ + 999) / 1000)
`define RDSR_PHASE_GAP_NS 20
`define RDSR_PHASE_GAP_CYC ((`RDSR_PHASE_GAP_NS * `RDSR_CLK_MHZ + 999) / 1000)
`endif

// File: design/rdsr_pkg.sv
`default_nettype none
package rdsr_pkg;
  typedef enum logic [1:0] {
    RDSR_DUAL = 2'b00,
    RDSR_DUAL_SEL = 2'b01,
    RDSR_SINGLE = 2'b10
  } rdsr_variant_t;
  typedef enum logic [2:0] {
    RDSR_IDLE = 3'b000,
    RDSR_PH1 = 3'b001,
    RDSR_GAP1 = 3'b010,
    RDSR_PH2 = 3'b011,
    RDSR_GAP2 = 3'b100
  } rdsr_seq_t;
endpackage : rdsr_pkg
`default_nettype wire

// File: design/rdsr_link_if.sv
`default_nettype none
interface rdsr_link_if;
  logic phase1N;
  logic phase2N;
  logic loadControl;
  logic [1:0] dataA;
  logic [1:0] dataB;
  logic [1:0] inputSelectA;
  logic [1:0] inputSelectB;
  logic outA;
  logic outB;
  modport device (input phase1N, phase2N, loadControl, dataA, dataB, inputSelectA, inputSelectB,
    output outA, outB);
  modport host (output phase1N, phase2N, loadControl, dataA, dataB, inputSelectA, inputSelectB,
    input outA, outB);
endinterface : rdsr_link_if
`default_nettype wire

// File: design/rdsr_device.sv
`include "rdsr_cfg.svh"
`default_nettype none
// Function
// R01: dual variant: two 1024-bit registers, shared load
// R02: load high recirculates, low takes new data
// R03: selectable variant: two inputs, each own select
// R04: single variant: one 2048-bit recirculating register
// R05: host supplies two separate clock phases
// R06: two interleaved halves, shift every phase pulse
// R07: host keeps both phases running continuously; code: only while run is high, otherwise both stay high in RDSR_IDLE
// R08: phase active when low, inactive high
// R09: master captures one phase, slave the other; code: master follows in each phase, slave half latches as that same phase ends
// R10: phases never both active; gap between them
// R11: inputs stable around phase rising edge
// R12: new output bit after phase falling edge
// R13: recirculated output repeats with register length
module rdsr_device
  import rdsr_pkg::*;
#(
  parameter rdsr_variant_t VARIANT = RDSR_DUAL,
  parameter int HALF_LEN = `RDSR_HALF_LEN
) (
  // system
  input wire logic clk_sys,
  input wire logic rstn,
  // link
  rdsr_link_if.device link
);
  // R01 R04 half length set by variant
  localparam int HLEN = (VARIANT == RDSR_SINGLE) ? HALF_LEN : HALF_LEN / 2;
  localparam bit HAS_B = (VARIANT != RDSR_SINGLE);

  // phase pins after synchronising, plus one stage for edges
  logic [1:0] ph1Sync_q;
  logic [1:0] ph2Sync_q;
  logic ph1Prev_q;
  logic ph2Prev_q;
  // load control, data and selects after synchronising
  logic [1:0] lcSync_q;
  logic [1:0] dASync_q;
  logic [1:0] dBSync_q;
  logic [1:0] sASync_q;
  logic [1:0] sBSync_q;
  logic [1:0] dA2_q;
  logic [1:0] dB2_q;
  logic [1:0] sA2_q;
  logic [1:0] sB2_q;
  // two interleaved halves per register, each an array of cells
  logic [HLEN-1:0] evenA_q;
  logic [HLEN-1:0] oddA_q;
  logic [HLEN-1:0] evenB_q;
  logic [HLEN-1:0] oddB_q;
  // master stage of the cell being written
  logic masterA_q;
  logic masterB_q;
  logic outA_q;
  logic outB_q;
  logic ph1Active;
  logic ph2Active;
  logic fall1;
  logic fall2;
  logic rise1;
  logic rise2;
  logic inA;
  logic inB;
  logic tailA;
  logic tailB;

  // phase level went from inactive to active
  function automatic logic goneActive(input logic prev, input logic cur);
    goneActive = prev & ~cur;
  endfunction : goneActive

  // phase level went from active to inactive
  function automatic logic goneIdle(input logic prev, input logic cur);
    goneIdle = ~prev & cur;
  endfunction : goneIdle

  function automatic logic pickIn(input rdsr_variant_t v, input logic [1:0] d, input logic [1:0] s);
    // R03 per-input select
    if (v == RDSR_DUAL_SEL) begin
      pickIn = (d[0] & s[0]) | (d[1] & s[1]);
    end else begin
      pickIn = d[0];
    end
  endfunction : pickIn

  // R13 each half loops on itself, so the period is the full length
  function automatic logic tailOf(input logic phase1Side, input logic [HLEN-1:0] evenHalf,
    input logic [HLEN-1:0] oddHalf);
    if (phase1Side) begin
      tailOf = evenHalf[HLEN-1];
    end else begin
      tailOf = oddHalf[HLEN-1];
    end
  endfunction : tailOf

  // R08 phase pins idle high: reset to the inactive level
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ph1Sync_q <= 2'h3;
      ph2Sync_q <= 2'h3;
      ph1Prev_q <= 1'b1;
      ph2Prev_q <= 1'b1;
    end else begin
      ph1Sync_q <= {ph1Sync_q[0], link.phase1N};
      ph2Sync_q <= {ph2Sync_q[0], link.phase2N};
      ph1Prev_q <= ph1Sync_q[1];
      ph2Prev_q <= ph2Sync_q[1];
    end
  end

  // load control idles at recirculate
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      lcSync_q <= 2'h3;
    end else begin
      lcSync_q <= {lcSync_q[0], link.loadControl};
    end
  end

  // data pins: two flip-flops first
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      dASync_q <= 2'h0;
      dBSync_q <= 2'h0;
      dA2_q <= 2'h0;
      dB2_q <= 2'h0;
    end else begin
      dASync_q <= link.dataA;
      dBSync_q <= link.dataB;
      dA2_q <= dASync_q;
      dB2_q <= dBSync_q;
    end
  end

  // select pins: two flip-flops first
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sASync_q <= 2'h0;
      sBSync_q <= 2'h0;
      sA2_q <= 2'h0;
      sB2_q <= 2'h0;
    end else begin
      sASync_q <= link.inputSelectA;
      sBSync_q <= link.inputSelectB;
      sA2_q <= sASync_q;
      sB2_q <= sBSync_q;
    end
  end

  // R08 low is active
  assign ph1Active = ~ph1Sync_q[1];
  assign ph2Active = ~ph2Sync_q[1];
  assign fall1 = goneActive(ph1Prev_q, ph1Sync_q[1]);
  assign fall2 = goneActive(ph2Prev_q, ph2Sync_q[1]);
  assign rise1 = goneIdle(ph1Prev_q, ph1Sync_q[1]);
  assign rise2 = goneIdle(ph2Prev_q, ph2Sync_q[1]);

  assign tailA = tailOf(ph1Active, evenA_q, oddA_q);
  assign tailB = tailOf(ph1Active, evenB_q, oddB_q);
  // R02 recirculate while load high
  assign inA = lcSync_q[1] ? tailA : pickIn(VARIANT, dA2_q, sA2_q);
  assign inB = lcSync_q[1] ? tailB : pickIn(VARIANT, dB2_q, sB2_q);

  // R09 master follows the cell input while a phase is active
  always_ff @(posedge clk_sys) begin
    if (ph1Active || ph2Active) begin
      masterA_q <= inA;
      masterB_q <= inB;
    end
  end

  // R06 slave halves take the master value as the phase ends
  always_ff @(posedge clk_sys) begin
    if (rise1) begin
      evenA_q <= {evenA_q[HLEN-2:0], masterA_q};
    end
    if (rise2) begin
      oddA_q <= {oddA_q[HLEN-2:0], masterA_q};
    end
  end

  // R01 second register shares the phases and load control
  always_ff @(posedge clk_sys) begin
    if (rise1) begin
      evenB_q <= {evenB_q[HLEN-2:0], masterB_q};
    end
    if (rise2) begin
      oddB_q <= {oddB_q[HLEN-2:0], masterB_q};
    end
  end

  // R12 output moves after a phase becomes active
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      outA_q <= 1'b0;
    end else if (fall1) begin
      outA_q <= evenA_q[HLEN-1];
    end else if (fall2) begin
      outA_q <= oddA_q[HLEN-1];
    end
  end

  // R04 second output idles low in the single variant
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      outB_q <= 1'b0;
    end else if (fall1) begin
      outB_q <= HAS_B ? evenB_q[HLEN-1] : 1'b0;
    end else if (fall2) begin
      outB_q <= HAS_B ? oddB_q[HLEN-1] : 1'b0;
    end
  end

  assign link.outA = outA_q;
  assign link.outB = outB_q;
endmodule : rdsr_device
`default_nettype wire

// File: design/rdsr_host.sv
`include "rdsr_cfg.svh"
`default_nettype none
module rdsr_host
  import rdsr_pkg::*;
(
  // system
  input wire logic clk_sys,
  input wire logic rstn,
  // user side
  input wire logic run,
  input wire logic load,
  input wire logic [1:0] userDataA,
  input wire logic [1:0] userDataB,
  input wire logic [1:0] userSelA,
  input wire logic [1:0] userSelB,
  output logic bitStrobe,
  output logic userOutA,
  output logic userOutB,
  // link
  rdsr_link_if.host link
);
  localparam int LOWC = `RDSR_PHASE_LOW_CYC;
  localparam int GAPC = `RDSR_PHASE_GAP_CYC;
  rdsr_seq_t state_q;
  logic [7:0] cnt_q;
  logic ph1_q, ph2_q, lc_q, strobe_q, oA_q, oB_q;
  logic [1:0] dA_q, dB_q, sA_q, sB_q, outASync_q, outBSync_q;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      outASync_q <= 2'h0;
      outBSync_q <= 2'h0;
    end else begin
      outASync_q <= {outASync_q[0], link.outA};
      outBSync_q <= {outBSync_q[0], link.outB};
    end
  end

  // R05 R07 R10 two phases, never overlapping, gap between
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_q <= RDSR_IDLE;
      cnt_q <= 8'h00;
      ph1_q <= 1'b1;
      ph2_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 8'h01;
      case (state_q)
        RDSR_IDLE: begin
          cnt_q <= 8'h00;
          if (run) begin
            state_q <= RDSR_PH1;
            ph1_q <= 1'b0;
          end
        end
        RDSR_PH1: if (cnt_q == 8'(LOWC - 1)) begin
          state_q <= RDSR_GAP1;
          ph1_q <= 1'b1;
          cnt_q <= 8'h00;
        end
        RDSR_GAP1: if (cnt_q == 8'(GAPC - 1)) begin
          state_q <= RDSR_PH2;
          ph2_q <= 1'b0;
          cnt_q <= 8'h00;
        end
        RDSR_PH2: if (cnt_q == 8'(LOWC - 1)) begin
          state_q <= RDSR_GAP2;
          ph2_q <= 1'b1;
          cnt_q <= 8'h00;
        end
        RDSR_GAP2: if (cnt_q == 8'(GAPC - 1)) begin
          state_q <= run ? RDSR_PH1 : RDSR_IDLE;
          ph1_q <= ~run;
          cnt_q <= 8'h00;
        end
        default: state_q <= RDSR_IDLE;
      endcase
    end
  end

  // R11 inputs change at the end of the gap, as the next phase goes low, stable over rising edges
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      lc_q <= 1'b1;
      dA_q <= 2'h0;
      dB_q <= 2'h0;
      sA_q <= 2'h0;
      sB_q <= 2'h0;
      strobe_q <= 1'b0;
      oA_q <= 1'b0;
      oB_q <= 1'b0;
    end else begin
      strobe_q <= 1'b0;
      if ((state_q == RDSR_GAP1 || state_q == RDSR_GAP2) && cnt_q == 8'(GAPC - 1)) begin
        lc_q <= ~load;
        dA_q <= userDataA;
        dB_q <= userDataB;
        sA_q <= userSelA;
        sB_q <= userSelB;
      end
      if ((state_q == RDSR_PH1 || state_q == RDSR_PH2) && cnt_q == 8'(LOWC - 1)) begin
        strobe_q <= 1'b1;
        oA_q <= outASync_q[1];
        oB_q <= outBSync_q[1];
      end
    end
  end

  assign link.phase1N = ph1_q;
  assign link.phase2N = ph2_q;
  assign link.loadControl = lc_q;
  assign link.dataA = dA_q;
  assign link.dataB = dB_q;
  assign link.inputSelectA = sA_q;
  assign link.inputSelectB = sB_q;
  assign bitStrobe = strobe_q;
  assign userOutA = oA_q;
  assign userOutB = oB_q;
endmodule : rdsr_host
`default_nettype wire

// File: test/rdsr_chk.sv
`default_nettype none
module rdsr_chk (
  // system
  input wire logic clk_sys,
  input wire logic rstn,
  // link
  input wire logic phase1N,
  input wire logic phase2N,
  input wire logic loadControl,
  input wire logic [1:0] dataA,
  input wire logic outA,
  input wire logic outB
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  sequence low1;
    (!phase1N) [*6] ##1 phase1N;
  endsequence
  sequence low2;
    (!phase2N) [*6] ##1 phase2N;
  endsequence
  not_both_a: assert property (phase1N || phase2N)
    else $error("both phases low");
  low_one_a: assert property ($fell(phase1N) |-> low1)
    else $error("phase one low time");
  low_two_a: assert property ($fell(phase2N) |-> low2)
    else $error("phase two low time");
  gap_a: assert property ($fell(phase1N) |-> $past(phase2N))
    else $error("no gap before phase one");
  alternate_a: assert property ($rose(phase1N) |=> $fell(phase2N))
    else $error("phase two does not follow");
  out_when_a: assert property ($changed(outA) |-> !phase1N || !phase2N)
    else $error("output moved outside a phase");
  out_hold_a: assert property ($changed(outA) |=> $stable(outA) [*5])
    else $error("output moved twice in a phase");
  outb_hold_a: assert property ($changed(outB) |=> $stable(outB) [*5])
    else $error("second output moved twice");
  in_stable_a: assert property ($rose(phase1N) || $rose(phase2N) |-> $stable(dataA) && $stable(loadControl))
    else $error("inputs moved at capture edge");
endmodule : rdsr_chk
`default_nettype wire

// File: test/tb_rdsr_device.sv
`default_nettype none
module tb_rdsr_device;
  import rdsr_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int N = 8;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic run = 1'b0;
  logic load = 1'b1;
  logic [1:0] userDataA = 2'h0;
  logic [1:0] userDataB = 2'h0;
  logic bitStrobe;
  logic userOutA;
  logic userOutB;
  logic a [32];
  logic b [32];
  logic [7:0] pat = 8'hb2;
  logic [1:0] selDataA = 2'h0;
  logic userOutC;
  logic userOutD;
  logic c [32];
  logic e [32];
  int onesA = 0;
  int onesC = 0;
  int mismatches = 0;
  int checks = 0;
  int cycles = 0;
  rdsr_link_if lk ();
  rdsr_device #(.VARIANT(RDSR_DUAL), .HALF_LEN(N)) u_rdsr_device (.clk_sys(clk_sys), .rstn(rstn), .link(lk));
  rdsr_host u_rdsr_host (.clk_sys(clk_sys), .rstn(rstn), .run(run), .load(load), .userDataA(userDataA),
    .userDataB(userDataB), .userSelA(2'h0), .userSelB(2'h0), .bitStrobe(bitStrobe), .userOutA(userOutA),
    .userOutB(userOutB), .link(lk));
  rdsr_chk u_rdsr_chk (.clk_sys(clk_sys), .rstn(rstn), .phase1N(lk.phase1N), .phase2N(lk.phase2N),
    .loadControl(lk.loadControl), .dataA(lk.dataA), .outA(lk.outA), .outB(lk.outB));
  // second pair runs the selectable-input variant on the same stimulus
  rdsr_link_if lkSel ();
  rdsr_device #(.VARIANT(RDSR_DUAL_SEL), .HALF_LEN(N)) u_rdsr_device_sel (.clk_sys(clk_sys), .rstn(rstn),
    .link(lkSel));
  rdsr_host u_rdsr_host_sel (.clk_sys(clk_sys), .rstn(rstn), .run(run), .load(load), .userDataA(selDataA),
    .userDataB(selDataA), .userSelA(2'h2), .userSelB(2'h1), .bitStrobe(), .userOutA(userOutC),
    .userOutB(userOutD), .link(lkSel));
  initial begin
    forever #10 clk_sys = ~clk_sys;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test;
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test
  // one bit time: sample outputs at the strobe, then present the next bit
  task automatic step(input logic d, input logic ld, output logic oa, output logic ob, output logic oc,
    output logic od);
    @(posedge clk_sys);
    while (bitStrobe !== 1'b1) @(posedge clk_sys);
    oa = userOutA;
    ob = userOutB;
    oc = userOutC;
    od = userOutD;
    userDataA <= {1'b0, d};
    userDataB <= {1'b0, ~d};
    selDataA <= {d, ~d};
    load <= ld;
  endtask : step
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 4000) begin
      mismatches++;
      stop_test();
    end
  end
  initial begin
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    run <= 1'b1;
    // fill with ones, then recirculate while feeding zeros
    for (int i = 0; i < 24; i++) step(1'b1, 1'b1, a[0], b[0], c[0], e[0]);
    for (int i = 0; i < 32; i++) step(1'b0, 1'b0, a[i], b[i], c[i], e[i]);
    for (int i = 24; i < 32; i++) begin
      check(a[i], 1'b1);
      check(b[i], 1'b0);
      check(c[i], 1'b1);
      check(e[i], 1'b0);
    end
    $display("test fill and hold done");
    for (int i = 0; i < 24; i++) step(pat[i % N], 1'b1, a[0], b[0], c[0], e[0]);
    for (int i = 0; i < 32; i++) step(1'b1, 1'b0, a[i], b[i], c[i], e[i]);
    for (int i = 16; i < 32; i++) begin
      check(a[i], a[i - N]);
      check(b[i], !a[i]);
      check(c[i], c[i - N]);
      check(e[i], !c[i]);
    end
    for (int i = 24; i < 32; i++) begin
      onesA += a[i];
      onesC += c[i];
    end
    // the stored pattern holds four ones in any eight bits
    check(8'(onesA), 8'h04);
    check(8'(onesC), 8'h04);
    $display("test pattern period done");
    stop_test();
  end
endmodule : tb_rdsr_device
`default_nettype wire
